/* testbench/ptpise_top_assertions.sv */
// Port-level checks of the timestamp-unit interrupt status block.
`include "ptpise_cfg.svh"

module ptpise_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [`PTPISE_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [`PTPISE_NCAP-1:0] capture_pin_i,
  input wire logic timer_a_hit_i,
  input wire logic timestamp_unit_summary_enable_i,
  input wire logic timestamp_unit_summary_event_o,
  input wire logic system_irq_o,
  input wire logic [`PTPISE_NCAP-1:0] capture_rise_o,
  input wire logic [`PTPISE_NCAP-1:0] capture_fall_o,
  input wire logic clock_event_a_o
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Only pin 0 is watched, so manual strobes must leave bit 0 alone.
  logic [2:0] hi_cnt_reg;
  logic [2:0] lo_cnt_reg;
  wire logic rd_ack = avs_read_i && !avs_waitrequest_o;
  wire logic ctrl_wr = avs_write_i && !avs_waitrequest_o &&
    avs_address_i == `PTPISE_OFF_CTRL;

  always_ff @(posedge clock_i) begin
    if (rst_i || !capture_pin_i[0]) hi_cnt_reg <= 3'h0;
    else if (hi_cnt_reg != 3'h7) hi_cnt_reg <= hi_cnt_reg + 3'h1;
    if (rst_i || capture_pin_i[0]) lo_cnt_reg <= 3'h0;
    else if (lo_cnt_reg != 3'h7) lo_cnt_reg <= lo_cnt_reg + 3'h1;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  irq_gate_a: assert property (system_irq_o |->
    $past(timestamp_unit_summary_enable_i) &&
    (timestamp_unit_summary_event_o || $past(timestamp_unit_summary_event_o)))
    else $error("irq without summary and enable");
  irq_raise_a: assert property (timestamp_unit_summary_event_o &&
    timestamp_unit_summary_enable_i |-> ##[0:2] system_irq_o)
    else $error("irq not raised");
  manual_rise_a: assert property (ctrl_wr &&
    avs_writedata_i[7:1] != 7'h00 |-> ##[1:3] capture_rise_o[7:1] != 7'h00)
    else $error("manual rise capture missing");
  manual_fall_a: assert property (ctrl_wr &&
    avs_writedata_i[15:9] != 7'h00 |-> ##[1:3] capture_fall_o[7:1] != 7'h00)
    else $error("manual fall capture missing");
  rise_filter_a: assert property (capture_rise_o[0] |->
    $past(hi_cnt_reg) >= 3'h4)
    else $error("rise accepted too early");
  fall_filter_a: assert property (capture_fall_o[0] |->
    $past(lo_cnt_reg) >= 3'h4)
    else $error("fall accepted too early");
  unmapped_zero_a: assert property (rd_ack && !(avs_address_i inside
    {`PTPISE_OFF_STATUS, `PTPISE_OFF_ENABLE, `PTPISE_OFF_CONFIG,
    `PTPISE_OFF_COUNT}) |-> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  status_rsvd_a: assert property (rd_ack &&
    avs_address_i == `PTPISE_OFF_STATUS |->
    (avs_readdata_o & ~`PTPISE_STATUS_MASK) == 32'h00000000)
    else $error("status reserved bits set");
  enable_rsvd_a: assert property (rd_ack &&
    avs_address_i == `PTPISE_OFF_ENABLE |->
    (avs_readdata_o & ~`PTPISE_STATUS_MASK) == 32'h00000000)
    else $error("enable reserved bits set");
  timer_pulse_a: assert property (timer_a_hit_i |=>
    clock_event_a_o [*8])
    else $error("channel A pulse too short");
endmodule

bind ptpise_top ptpise_chk chk (.clock_i(clock_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .capture_pin_i(capture_pin_i), .timer_a_hit_i(timer_a_hit_i),
  .timestamp_unit_summary_enable_i(timestamp_unit_summary_enable_i),
  .timestamp_unit_summary_event_o(timestamp_unit_summary_event_o),
  .system_irq_o(system_irq_o), .capture_rise_o(capture_rise_o),
  .capture_fall_o(capture_fall_o), .clock_event_a_o(clock_event_a_o));

/* testbench/tb.sv */
// Self-checking bench of the timestamp-unit interrupt status block.
`include "ptpise_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [8:0] avs_address_i = 9'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [7:0] capture_pin_i = 8'h00;
  logic [2:0] egress_stored_i = 3'h0;
  logic [2:0] egress_pop_i = 3'h0;
  logic [2:0] ingress_stored_i = 3'h0;
  logic [2:0] ingress_pop_i = 3'h0;
  logic timer_a_hit_i = 1'b0;
  logic timer_b_hit_i = 1'b0;
  logic timestamp_unit_summary_enable_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic sum_o;
  logic irq_o;
  logic ev_b_o;
  logic [31:0] rd;
  int failures = 0;
  int comparisons = 0;

  always #5 clock_i = ~clock_i;

  ptpise_top DUT (.clock_i(clock_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .capture_pin_i(capture_pin_i),
    .egress_stored_i(egress_stored_i), .egress_pop_i(egress_pop_i),
    .ingress_stored_i(ingress_stored_i), .ingress_pop_i(ingress_pop_i),
    .timer_a_hit_i(timer_a_hit_i), .timer_b_hit_i(timer_b_hit_i),
    .timestamp_unit_summary_enable_i(timestamp_unit_summary_enable_i),
    .timestamp_unit_summary_event_o(sum_o), .system_irq_o(irq_o),
    .capture_rise_o(), .capture_fall_o(), .clock_event_a_o(),
    .clock_event_b_o(ev_b_o));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Holds the request until waitrequest is seen low, then releases it.
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rdchk(`PTPISE_OFF_STATUS, 32'h00000000);
    rdchk(`PTPISE_OFF_ENABLE, 32'h00000000);
    rdchk(9'h104, 32'h00000000);
    bus(1'b1, `PTPISE_OFF_ENABLE, 32'hFFFFFFFF);
    rdchk(`PTPISE_OFF_ENABLE, 32'hFFFF7703);
    avs_byteenable_i <= 4'h1;
    bus(1'b1, `PTPISE_OFF_ENABLE, 32'h00000000);
    avs_byteenable_i <= 4'hF;
    rdchk(`PTPISE_OFF_ENABLE, 32'hFFFF7700);
    bus(1'b1, `PTPISE_OFF_ENABLE, 32'h00000001);
  endtask

  task automatic t_timer;
    timestamp_unit_summary_enable_i <= 1'b1;
    timer_b_hit_i <= 1'b1;
    cyc(1);
    timer_b_hit_i <= 1'b0;
    cyc(3);
    chk({31'h0, sum_o}, 32'h0);
    rdchk(`PTPISE_OFF_STATUS, 32'h00000002);
    timer_a_hit_i <= 1'b1;
    cyc(1);
    timer_a_hit_i <= 1'b0;
    cyc(3);
    chk({30'h0, sum_o, irq_o}, 32'h3);
    timestamp_unit_summary_enable_i <= 1'b0;
    cyc(3);
    chk({30'h0, sum_o, irq_o}, 32'h2);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'h00000000);
    rdchk(`PTPISE_OFF_STATUS, 32'h00000003);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'h00000001);
    cyc(2);
    chk({31'h0, sum_o}, 32'h0);
    rdchk(`PTPISE_OFF_STATUS, 32'h00000002);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'h00000002);
  endtask

  // The hit lands in the acknowledge cycle, so clear and set share an edge.
  task automatic t_race;
    avs_address_i <= `PTPISE_OFF_STATUS;
    avs_writedata_i <= 32'h00000001;
    avs_write_i <= 1'b1;
    @(posedge clock_i);
    timer_a_hit_i <= 1'b1;
    @(posedge clock_i);
    chk({31'h0, avs_waitrequest_o}, 32'h0);
    timer_a_hit_i <= 1'b0;
    avs_write_i <= 1'b0;
    cyc(2);
    rdchk(`PTPISE_OFF_STATUS, 32'h00000001);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'h00000001);
  endtask

  task automatic t_stamps;
    repeat (5) begin
      egress_stored_i <= 3'b010;
      cyc(1);
      egress_stored_i <= 3'b000;
      cyc(1);
    end
    ingress_stored_i <= 3'b100;
    cyc(1);
    ingress_stored_i <= 3'b000;
    cyc(2);
    rdchk(`PTPISE_OFF_COUNT, 32'h00400100);
    rdchk(`PTPISE_OFF_STATUS, 32'h00002400);
    egress_pop_i <= 3'b010;
    ingress_pop_i <= 3'b101;
    cyc(1);
    egress_pop_i <= 3'b000;
    ingress_pop_i <= 3'b000;
    cyc(1);
    rdchk(`PTPISE_OFF_COUNT, 32'h00300000);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'h00002400);
    rdchk(`PTPISE_OFF_STATUS, 32'h00000000);
  endtask

  task automatic t_capture;
    bus(1'b1, `PTPISE_OFF_CTRL, 32'h0000FEFE);
    cyc(2);
    rdchk(`PTPISE_OFF_STATUS, 32'hFEFE0000);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'hFFFFFFFF);
    capture_pin_i <= 8'h01;
    cyc(2);
    capture_pin_i <= 8'h00;
    cyc(8);
    rdchk(`PTPISE_OFF_STATUS, 32'h00000000);
    capture_pin_i <= 8'h01;
    cyc(10);
    capture_pin_i <= 8'h00;
    cyc(10);
    rdchk(`PTPISE_OFF_STATUS, 32'h01010000);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'hFFFFFFFF);
  endtask

  // Channel B in level mode; timer A cleared by a rising edge on pin 1.
  task automatic t_channel;
    bus(1'b1, `PTPISE_OFF_CONFIG, 32'h00000138);
    rdchk(`PTPISE_OFF_CONFIG, 32'h00000138);
    timer_a_hit_i <= 1'b1;
    timer_b_hit_i <= 1'b1;
    cyc(1);
    timer_a_hit_i <= 1'b0;
    timer_b_hit_i <= 1'b0;
    cyc(3);
    chk({31'h0, ev_b_o}, 32'h1);
    capture_pin_i <= 8'h02;
    cyc(10);
    rdchk(`PTPISE_OFF_STATUS, 32'h00020002);
    bus(1'b1, `PTPISE_OFF_STATUS, 32'h00020002);
    cyc(2);
    chk({31'h0, ev_b_o}, 32'h0);
    capture_pin_i <= 8'h00;
    cyc(10);
    bus(1'b1, `PTPISE_OFF_CONFIG, 32'h00000004);
    timer_b_hit_i <= 1'b1;
    cyc(1);
    timer_b_hit_i <= 1'b0;
    cyc(2);
    chk({31'h0, ev_b_o}, 32'h1);
    bus(1'b1, `PTPISE_OFF_CONFIG, 32'h0000000C);
    cyc(1);
    chk({31'h0, ev_b_o}, 32'h0);
  endtask

  // ****************************************************************
  // Sequence and verdict
  // ****************************************************************
  task automatic report_and_stop;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(8);
    rst_i <= 1'b0;
    cyc(1);
    t_regs();
    t_timer();
    t_race();
    t_stamps();
    t_capture();
    t_channel();
    report_and_stop();
  end

  // The scenarios need about two hundred cycles; this allows fifty times more.
  initial begin
    #100000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule

/* verilog/ptpise_cfg.svh */
// Constants of the timestamp-unit interrupt status and enable block.
//
// Operation
// (R1) Writing one clears a status bit.
// (R2) Summary event is any enabled set status.
// (R3) Status latches regardless of enable bits.
// (R4) System interrupt needs summary and its enable.
// (R5) Bits 31:24 flag falling capture edges.
// (R6) Bits 23:16 flag rising capture edges.
// (R7) Capture edges count after over 40 ns.
// (R8) Manual capture sets edge flags too.
// (R9) Bits 14:12 flag per-port egress stamps.
// (R10) Up to four stamps counted per port, direction.
// (R11) Bits 10:8 flag per-port ingress stamps.
// (R12) Bit 1 flags channel B target reached.
// (R13) Bit 0 flags channel A target reached.
// (R14) Filtered capture edge may clear timer bits.
// (R15) Enable register mirrors status layout, resets zero.
// (R16) Mode 10 drives timer bit onto channel.
// (R17) Hardware set wins over software clear.
// (R18) Reserved bits read zero, ignore writes.
`ifndef PTPISE_CFG_SVH
`define PTPISE_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PTPISE_ADDR_W 9
`define PTPISE_OFF_STATUS 9'h108
`define PTPISE_OFF_ENABLE 9'h10C
`define PTPISE_OFF_CTRL 9'h180
`define PTPISE_OFF_CONFIG 9'h184
`define PTPISE_OFF_COUNT 9'h188
`define PTPISE_STATUS_MASK 32'hFFFF7703
`define PTPISE_CONFIG_MASK 32'h00003FFF
`define PTPISE_ZERO32 32'h00000000

// ****************************************************************
// Status and enable field layout
// ****************************************************************
`define PTPISE_FALL_LSB 24
`define PTPISE_RISE_LSB 16
`define PTPISE_EGR_LSB 12
`define PTPISE_ING_LSB 8
`define PTPISE_TMR_B_BIT 1
`define PTPISE_TMR_A_BIT 0
`define PTPISE_NCAP 8
`define PTPISE_NPORT 3

// ****************************************************************
// Control, configuration and count fields
// ****************************************************************
`define PTPISE_MAN_RISE_LSB 0
`define PTPISE_MAN_FALL_LSB 8
`define PTPISE_MODE_A_LSB 0
`define PTPISE_MODE_B_LSB 2
`define PTPISE_CLR_EN_A_BIT 4
`define PTPISE_SEL_A_LSB 5
`define PTPISE_POL_A_BIT 8
`define PTPISE_CLR_EN_B_BIT 9
`define PTPISE_SEL_B_LSB 10
`define PTPISE_POL_B_BIT 13
`define PTPISE_ING_CNT_LSB 0
`define PTPISE_EGR_CNT_LSB 16
`define PTPISE_CNT_STRIDE 4

// ****************************************************************
// Timing and depth
// ****************************************************************
`define PTPISE_CLK_NS 10
`define PTPISE_FILT_NS 40
`define PTPISE_FILT_CYC ((`PTPISE_FILT_NS / `PTPISE_CLK_NS) + 1)
`define PTPISE_PULSE_NS 100
`define PTPISE_PULSE_CYC (`PTPISE_PULSE_NS / `PTPISE_CLK_NS)
`define PTPISE_STAMP_DEPTH 4
`define PTPISE_CNT_W 3

`endif

/* verilog/ptpise_edge_filter.sv */
// Qualifies capture input edges by a minimum stable time.
`include "ptpise_cfg.svh"

module ptpise_edge_filter (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [`PTPISE_NCAP-1:0] pin_i,
  output logic [`PTPISE_NCAP-1:0] rise_o,
  output logic [`PTPISE_NCAP-1:0] fall_o
);

  // A pin held high through reset reports one rise once it is qualified.
  logic [`PTPISE_NCAP-1:0] level_reg;

  for (genvar i = 0; i < `PTPISE_NCAP; i++) begin : g_bit
    logic [2:0] cnt_reg;
    wire differs = pin_i[i] != level_reg[i];
    wire done = differs && (cnt_reg == 3'(`PTPISE_FILT_CYC - 1));

    always_ff @(posedge clock_i) begin
      if (rst_i || !differs || done) begin
        cnt_reg <= 3'h0;
      end else begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        level_reg[i] <= 1'b0;
        rise_o[i] <= 1'b0;
        fall_o[i] <= 1'b0;
      end else begin
        if (done) begin
          level_reg[i] <= pin_i[i]; // [R7]
        end
        rise_o[i] <= done && pin_i[i]; // [R7]
        fall_o[i] <= done && !pin_i[i]; // [R7]
      end
    end
  end

endmodule

/* verilog/ptpise_pkg.sv */
// Types of the timestamp-unit interrupt status and enable block.
package ptpise_pkg;

  typedef enum logic [1:0] {
    PTPISE_ST_IDLE = 2'b01,
    PTPISE_ST_ACK = 2'b10
  } ptpise_state_e;

  typedef enum logic [1:0] {
    PTPISE_MODE_PULSE = 2'b00,
    PTPISE_MODE_TOGGLE = 2'b01,
    PTPISE_MODE_LEVEL = 2'b10,
    PTPISE_MODE_RSVD = 2'b11
  } ptpise_mode_e;

endpackage

/* verilog/ptpise_stamp_count.sv */
// Counts timestamp entries held for one port and direction.
`include "ptpise_cfg.svh"

module ptpise_stamp_count (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  output logic accept_o,
  output logic [`PTPISE_CNT_W-1:0] count_o
);

  logic [`PTPISE_CNT_W-1:0] count_reg;
  wire full = count_reg == `PTPISE_CNT_W'(`PTPISE_STAMP_DEPTH);
  wire empty = count_reg == `PTPISE_CNT_W'(0);
  wire take = pop_i && !empty;

  // A stamp arriving while full with no pop in that cycle is dropped, and so raises no flag.
  assign accept_o = push_i && (!full || take); // [R10]
  assign count_o = count_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_reg <= `PTPISE_CNT_W'(0);
    end else if (accept_o && !take) begin
      count_reg <= count_reg + `PTPISE_CNT_W'(1); // [R10]
    end else if (take && !accept_o) begin
      count_reg <= count_reg - `PTPISE_CNT_W'(1); // [R10]
    end
  end

endmodule

/* verilog/ptpise_top.sv */
// Timestamp-unit interrupt status, enable and clock event outputs.
//
// Design decision made here: register access over Avalon-MM.
`include "ptpise_cfg.svh"

module ptpise_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [`PTPISE_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [`PTPISE_NCAP-1:0] capture_pin_i,
  input wire logic [`PTPISE_NPORT-1:0] egress_stored_i,
  input wire logic [`PTPISE_NPORT-1:0] egress_pop_i,
  input wire logic [`PTPISE_NPORT-1:0] ingress_stored_i,
  input wire logic [`PTPISE_NPORT-1:0] ingress_pop_i,
  input wire logic timer_a_hit_i,
  input wire logic timer_b_hit_i,
  input wire logic timestamp_unit_summary_enable_i,
  output logic timestamp_unit_summary_event_o,
  output logic system_irq_o,
  output logic [`PTPISE_NCAP-1:0] capture_rise_o,
  output logic [`PTPISE_NCAP-1:0] capture_fall_o,
  output logic clock_event_a_o,
  output logic clock_event_b_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Byte enables widen to one mask shared by merge and clear.
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [31:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  function automatic logic gpio_hit(input logic [7:0] rise,
      input logic [7:0] fall, input logic [2:0] sel, input logic pol);
    gpio_hit = pol ? rise[sel] : fall[sel];
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  ptpise_pkg::ptpise_state_e state_reg;
  ptpise_pkg::ptpise_state_e state_next;
  logic [31:0] readdata_reg;

  wire st_ack = state_reg == ptpise_pkg::PTPISE_ST_ACK;
  wire req = avs_read_i || avs_write_i;
  wire wr_go = st_ack && avs_write_i;
  // Byte enables gate the write-one clear as well as plain writes.
  wire [31:0] wmask = be_mask(avs_byteenable_i);
  wire hit_status = avs_address_i == `PTPISE_OFF_STATUS;
  wire hit_enable = avs_address_i == `PTPISE_OFF_ENABLE;
  wire hit_ctrl = avs_address_i == `PTPISE_OFF_CTRL;
  wire hit_config = avs_address_i == `PTPISE_OFF_CONFIG;
  wire hit_count = avs_address_i == `PTPISE_OFF_COUNT;

  // The answer is fixed at one wait cycle so read data is a clean flop.
  always_comb begin
    case (state_reg)
      ptpise_pkg::PTPISE_ST_IDLE: begin
        state_next = req ? ptpise_pkg::PTPISE_ST_ACK
                         : ptpise_pkg::PTPISE_ST_IDLE;
      end
      ptpise_pkg::PTPISE_ST_ACK: begin
        state_next = ptpise_pkg::PTPISE_ST_IDLE;
      end
      default: begin
        state_next = ptpise_pkg::PTPISE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ptpise_pkg::PTPISE_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest_o = !st_ack;
  assign avs_readdata_o = readdata_reg;

  // ****************************************************************
  // Capture inputs
  // ****************************************************************
  wire [`PTPISE_NCAP-1:0] pin_rise;
  wire [`PTPISE_NCAP-1:0] pin_fall;

  ptpise_edge_filter u_filter (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(capture_pin_i),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // ****************************************************************
  // Timestamp counts
  // ****************************************************************
  // A full queue with no same-cycle pop drops the stamp, so no flag is raised for it.
  wire [`PTPISE_NPORT-1:0] egr_accept;
  wire [`PTPISE_NPORT-1:0] ing_accept;
  logic [31:0] count_word;

  for (genvar p = 0; p < `PTPISE_NPORT; p++) begin : g_port
    wire [`PTPISE_CNT_W-1:0] egr_cnt;
    wire [`PTPISE_CNT_W-1:0] ing_cnt;

    ptpise_stamp_count u_egr (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .push_i(egress_stored_i[p]),
      .pop_i(egress_pop_i[p]),
      .accept_o(egr_accept[p]),
      .count_o(egr_cnt)
    );

    ptpise_stamp_count u_ing (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .push_i(ingress_stored_i[p]),
      .pop_i(ingress_pop_i[p]),
      .accept_o(ing_accept[p]),
      .count_o(ing_cnt)
    );

    assign count_word[`PTPISE_EGR_CNT_LSB + `PTPISE_CNT_STRIDE * p +:
        `PTPISE_CNT_STRIDE] = {1'b0, egr_cnt}; // [R10]
    assign count_word[`PTPISE_ING_CNT_LSB + `PTPISE_CNT_STRIDE * p +:
        `PTPISE_CNT_STRIDE] = {1'b0, ing_cnt}; // [R10]
  end

  // Unused nibbles of the count word read as zero.
  assign count_word[15:12] = 4'h0;
  assign count_word[31:28] = 4'h0;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] enable_reg;
  logic [31:0] config_reg;
  logic [`PTPISE_NCAP-1:0] man_rise;
  logic [`PTPISE_NCAP-1:0] man_fall;

  // Manual capture bits are strobes; the control word keeps no state.
  wire [31:0] ctrl_wr = (wr_go && hit_ctrl) ? (avs_writedata_i & wmask)
                                            : `PTPISE_ZERO32;
  assign man_rise = ctrl_wr[`PTPISE_MAN_RISE_LSB +: `PTPISE_NCAP];
  assign man_fall = ctrl_wr[`PTPISE_MAN_FALL_LSB +: `PTPISE_NCAP];

  wire [`PTPISE_NCAP-1:0] rise_evt = pin_rise | man_rise; // [R8]
  wire [`PTPISE_NCAP-1:0] fall_evt = pin_fall | man_fall; // [R8]

  wire [1:0] mode_a = config_reg[`PTPISE_MODE_A_LSB +: 2];
  wire [1:0] mode_b = config_reg[`PTPISE_MODE_B_LSB +: 2];
  wire [2:0] sel_a = config_reg[`PTPISE_SEL_A_LSB +: 3];
  wire [2:0] sel_b = config_reg[`PTPISE_SEL_B_LSB +: 3];
  // Only filtered pin edges clear a timer; manual strobes never do.
  wire gpio_clr_a = config_reg[`PTPISE_CLR_EN_A_BIT] && gpio_hit(pin_rise,
      pin_fall, sel_a, config_reg[`PTPISE_POL_A_BIT]); // [R14]
  wire gpio_clr_b = config_reg[`PTPISE_CLR_EN_B_BIT] && gpio_hit(pin_rise,
      pin_fall, sel_b, config_reg[`PTPISE_POL_B_BIT]); // [R14]

  wire [31:0] status_set =
      ({24'h000000, fall_evt} << `PTPISE_FALL_LSB) | // [R5]
      ({24'h000000, rise_evt} << `PTPISE_RISE_LSB) | // [R6]
      ({29'h00000000, egr_accept} << `PTPISE_EGR_LSB) | // [R9]
      ({29'h00000000, ing_accept} << `PTPISE_ING_LSB) | // [R11]
      ({31'h00000000, timer_b_hit_i} << `PTPISE_TMR_B_BIT) | // [R12]
      ({31'h00000000, timer_a_hit_i} << `PTPISE_TMR_A_BIT); // [R13]

  wire [31:0] sw_clr = (wr_go && hit_status) ? (avs_writedata_i & wmask)
                                             : `PTPISE_ZERO32; // [R1]
  wire [31:0] hw_clr =
      ({31'h00000000, gpio_clr_b} << `PTPISE_TMR_B_BIT) |
      ({31'h00000000, gpio_clr_a} << `PTPISE_TMR_A_BIT); // [R14]

  // Set is applied last so a same-cycle event survives the clear.
  assign status_next = ((status_reg & ~(sw_clr | hw_clr)) | status_set)
      & `PTPISE_STATUS_MASK; // [R3] [R17] [R18]

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status_reg <= `PTPISE_ZERO32;
    end else begin
      status_reg <= status_next;
    end
  end

  // Reserved enable bits are masked on write and so read as zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      enable_reg <= `PTPISE_ZERO32; // [R15]
    end else if (wr_go && hit_enable) begin
      enable_reg <= merge(enable_reg, avs_writedata_i,
          wmask & `PTPISE_STATUS_MASK); // [R15] [R18]
    end
  end

  // Configuration bits outside the defined fields stay at zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      config_reg <= `PTPISE_ZERO32;
    end else if (wr_go && hit_config) begin
      config_reg <= merge(config_reg, avs_writedata_i,
          wmask & `PTPISE_CONFIG_MASK); // [R18]
    end
  end

  // The control word holds only strobes, so it reads back as zero.
  wire [31:0] rd_mux =
      hit_status ? status_reg :
      hit_enable ? enable_reg :
      hit_config ? config_reg :
      hit_count ? count_word : `PTPISE_ZERO32; // [R18]

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      readdata_reg <= `PTPISE_ZERO32;
    end else if (!st_ack && avs_read_i) begin
      readdata_reg <= rd_mux;
    end
  end

  // ****************************************************************
  // Summary and system interrupt
  // ****************************************************************
  // Both outputs are flops, so a write never glitches the summary.
  wire summary = |(status_reg & enable_reg); // [R2]

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timestamp_unit_summary_event_o <= 1'b0;
      system_irq_o <= 1'b0;
      capture_rise_o <= `PTPISE_NCAP'(0);
      capture_fall_o <= `PTPISE_NCAP'(0);
    end else begin
      timestamp_unit_summary_event_o <= summary; // [R2]
      system_irq_o <= summary && timestamp_unit_summary_enable_i; // [R4]
      capture_rise_o <= rise_evt; // [R6]
      capture_fall_o <= fall_evt; // [R5]
    end
  end

  // ****************************************************************
  // Clock event channel outputs
  // ****************************************************************
  // Level mode follows the status flop and trails the flag by a cycle.
  wire [1:0] ch_hit = {timer_b_hit_i, timer_a_hit_i};
  wire [1:0] ch_flag = {status_reg[`PTPISE_TMR_B_BIT],
      status_reg[`PTPISE_TMR_A_BIT]};
  wire [1:0] ch_mode [2];
  logic [1:0] ch_out;

  assign ch_mode[0] = mode_a;
  assign ch_mode[1] = mode_b;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [3:0] pulse_reg;
    logic toggle_reg;
    wire pulse_on = pulse_reg != 4'h0;
    wire [3:0] pulse_next = ch_hit[c] ? 4'(`PTPISE_PULSE_CYC) :
        (pulse_on ? pulse_reg - 4'h1 : 4'h0);
    wire sel_out =
        (ch_mode[c] == ptpise_pkg::PTPISE_MODE_PULSE) ? (pulse_next != 4'h0) :
        (ch_mode[c] == ptpise_pkg::PTPISE_MODE_TOGGLE) ?
            (toggle_reg ^ ch_hit[c]) :
        (ch_mode[c] == ptpise_pkg::PTPISE_MODE_LEVEL) ?
            ch_flag[c] : 1'b0; // [R16]

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        pulse_reg <= 4'h0;
        toggle_reg <= 1'b0;
        ch_out[c] <= 1'b0;
      end else begin
        pulse_reg <= pulse_next;
        toggle_reg <= toggle_reg ^ ch_hit[c];
        ch_out[c] <= sel_out; // [R16]
      end
    end
  end

  // ****************************************************************
  // Channel output pins
  // ****************************************************************

  assign clock_event_a_o = ch_out[0];
  assign clock_event_b_o = ch_out[1];

endmodule
